// >>> src/csc_map.svh
// Constants of the clock sync correction block
// How it works
// - Sync measurement tables are cleared in the network idle time before a cycle starts.
// - Even-cycle entries are cleared in the odd cycle's idle time and odd entries in the even's.
// - Startup frames are counted with one counter for channel A and one for channel B.
// - The startup frame count used for evaluation is the larger of the two channel counts.
// - The offset correction term is checked against its limit before external offset is added.
// - The rate correction term is checked against its limit before external rate is added.
// - On a macrotick reset the host view goes to zero at once while internal counting runs on.
// - Up to sixteen sync nodes per cycle are accepted; that maximum is fixed.
`ifndef CSC_MAP_SVH
`define CSC_MAP_SVH
`define CSC_MAX_SYNC_NODES 16
`define CSC_IDX_W          4
`define CSC_CNT_W          5
`define CSC_ID_W           11
`define CSC_DEV_W          16
`define CSC_TERM_W         17
`define CSC_MT_W           14
`define CSC_SU_W           5
`define CSC_SU_MAX         5'h1f
`define CSC_MT_RUNON       2'h2
`define CSC_PAR_EVEN       1'b0
`define CSC_PAR_ODD        1'b1
`define CSC_TERM_POS_MAX   17'h0_ffff
`define CSC_TERM_NEG_MAX   17'h1_0000
`endif

// >>> src/csc_pkg.sv
// Types of the clock sync correction block
`include "csc_map.svh"
package csc_pkg;
  typedef struct packed {
    logic                          valid;
    logic                          chan;
    logic                          startup;
    logic [`CSC_ID_W-1:0]          id;
    logic signed [`CSC_DEV_W-1:0]  dev;
  } csc_frame_t;

  typedef struct packed {
    logic [`CSC_TERM_W-1:0]        offset_limit;
    logic [`CSC_TERM_W-1:0]        rate_limit;
    logic signed [`CSC_TERM_W-1:0] ext_offset;
    logic signed [`CSC_TERM_W-1:0] ext_rate;
  } csc_cfg_t;

  typedef struct packed {
    logic                          done;
    logic                          offset_fail;
    logic                          rate_fail;
    logic signed [`CSC_TERM_W-1:0] offset_correction_term;
    logic signed [`CSC_TERM_W-1:0] rate_correction_term;
  } csc_result_t;

  typedef enum logic [1:0] {
    CSC_IDLE = 2'b00,
    CSC_SCAN = 2'b01,
    CSC_DONE = 2'b10
  } csc_state_t;
endpackage

// >>> src/csc_calc.sv
// Limit check and external correction of the offset and rate terms
`timescale 1ns/1ps
`default_nettype none
`include "csc_map.svh"
module csc_calc (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rstn,
  // Start strobe, measured midpoints and configuration
  input  wire logic                          go,
  input  wire logic                          offset_any,
  input  wire logic signed [`CSC_TERM_W-1:0] offset_raw,
  input  wire logic                          rate_any,
  input  wire logic signed [`CSC_TERM_W-1:0] rate_raw,
  input  wire csc_pkg::csc_cfg_t             cfg,
  // Result
  output var  csc_pkg::csc_result_t          result
);
  import csc_pkg::*;

  function automatic logic over(input logic signed [`CSC_TERM_W-1:0] v,
                                input logic [`CSC_TERM_W-1:0] lim);
    logic [`CSC_TERM_W-1:0] mag;
    mag = v[`CSC_TERM_W-1] ? `CSC_TERM_W'(-v) : `CSC_TERM_W'(v);
    return mag > lim;
  endfunction

  // Clamp bounds a failed term to the limit; the external term is added after, so the applied step can exceed it
  function automatic logic signed [`CSC_TERM_W-1:0] sat(input logic signed [`CSC_TERM_W-1:0] v,
                                                       input logic [`CSC_TERM_W-1:0] lim);
    if (!over(v, lim))
      return v;
    return v[`CSC_TERM_W-1] ? -$signed(lim) : $signed(lim);
  endfunction

  always_ff @(posedge clk) begin
    if (!rstn) begin
      result <= '0;
    end else begin
      result.done <= go;
      if (go) begin
        result.offset_fail <= !offset_any || over(offset_raw, cfg.offset_limit);
        result.rate_fail   <= !rate_any || over(rate_raw, cfg.rate_limit);
        result.offset_correction_term <= sat(offset_raw, cfg.offset_limit) + cfg.ext_offset;
        result.rate_correction_term   <= sat(rate_raw, cfg.rate_limit) + cfg.ext_rate;
      end
    end
  end

  offset_check_a: assert property (@(posedge clk) disable iff (!rstn)
    go && offset_any |=> result.offset_fail == over($past(offset_raw), $past(cfg.offset_limit)))
    else $error("offset checked against wrong value");

  rate_check_a: assert property (@(posedge clk) disable iff (!rstn)
    go && rate_any && !over(rate_raw, cfg.rate_limit)
    |=> !result.rate_fail && result.rate_correction_term == $past(rate_raw) + $past(cfg.ext_rate))
    else $error("rate term not raw plus external");
endmodule
`default_nettype wire

// >>> src/csc_top.sv
// Sync frame tables, startup counting, correction scan and macrotick view
`timescale 1ns/1ps
`default_nettype none
`include "csc_map.svh"
module csc_top (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  // Cycle timing
  input  wire logic                    nit_start,
  input  wire logic                    cycle_odd,
  input  wire logic                    calc_start,
  // Sync frame measurements
  input  wire csc_pkg::csc_frame_t     frame,
  // Correction limits and external terms
  input  wire csc_pkg::csc_cfg_t       cfg,
  // Macrotick generation
  input  wire logic                    mt_tick,
  input  wire logic                    mt_reset,
  // Results
  output var  csc_pkg::csc_result_t    result,
  output logic [`CSC_SU_W-1:0]         startup_count,
  output logic [`CSC_CNT_W-1:0]        sync_nodes_even,
  output logic [`CSC_CNT_W-1:0]        sync_nodes_odd,
  output logic                         table_overflow,
  output logic                         calc_busy,
  output logic [`CSC_MT_W-1:0]         macrotick_value,
  output logic [`CSC_MT_W-1:0]         mt_internal
);
  import csc_pkg::*;

  localparam int N = `CSC_MAX_SYNC_NODES;

  logic [`CSC_ID_W-1:0]         tid   [0:1][0:N-1];
  logic signed [`CSC_DEV_W-1:0] dev_a [0:1][0:N-1];
  logic signed [`CSC_DEV_W-1:0] dev_b [0:1][0:N-1];
  logic                         va    [0:1][0:N-1];
  logic                         vb    [0:1][0:N-1];
  logic [`CSC_CNT_W-1:0]        cnt   [0:1];
  logic                         wpar;
  logic                         cpar;
  logic                         hit;
  logic [`CSC_IDX_W-1:0]        hit_idx;
  logic                         full;
  logic                         su_clear;
  logic [`CSC_SU_W-1:0]         su_a;
  logic [`CSC_SU_W-1:0]         su_b;
  csc_state_t                   state;
  logic [`CSC_IDX_W-1:0]        idx;
  logic signed [`CSC_TERM_W-1:0] omin, omax, rmin, rmax;
  logic                         oany, rany;
  logic signed [`CSC_TERM_W-1:0] next_omin, next_omax, next_rmin, next_rmax;
  logic                         next_oany, next_rany;
  logic                         go;
  logic [1:0]                   runon;
  logic [`CSC_MT_W-1:0]         next_mt;

  function automatic logic signed [`CSC_TERM_W-1:0] wide(input logic signed [`CSC_DEV_W-1:0] d);
    return `CSC_TERM_W'(d);
  endfunction

  function automatic logic signed [`CSC_TERM_W-1:0] mid(input logic signed [`CSC_TERM_W-1:0] a,
                                                       input logic signed [`CSC_TERM_W-1:0] b);
    logic signed [`CSC_TERM_W:0] s;
    s = (`CSC_TERM_W+1)'(a) + (`CSC_TERM_W+1)'(b);
    return s[`CSC_TERM_W:1];
  endfunction

  assign wpar     = cycle_odd;
  assign cpar     = !cycle_odd;
  assign full     = cnt[wpar] == `CSC_CNT_W'(N);
  assign su_clear = nit_start && cycle_odd;

  // Existing entry of the same node is reused so the two channels share one slot
  always_comb begin
    hit     = 1'b0;
    hit_idx = '0;
    for (int i = 0; i < N; i++) begin
      if (!hit && `CSC_CNT_W'(i) < cnt[wpar] && tid[wpar][i] == frame.id) begin
        hit     = 1'b1;
        hit_idx = `CSC_IDX_W'(i);
      end
    end
  end

  // Clearing one parity while the other is written never touches the same slots
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int p = 0; p < 2; p++) begin
        cnt[p] <= '0;
        for (int i = 0; i < N; i++) begin
          tid[p][i]   <= '0;
          dev_a[p][i] <= '0;
          dev_b[p][i] <= '0;
          va[p][i]    <= 1'b0;
          vb[p][i]    <= 1'b0;
        end
      end
    end else begin
      if (nit_start) begin
        cnt[cpar] <= '0;
        for (int i = 0; i < N; i++) begin
          va[cpar][i] <= 1'b0;
          vb[cpar][i] <= 1'b0;
        end
      end
      if (frame.valid && (hit || !full)) begin
        if (!hit) begin
          tid[wpar][cnt[wpar][`CSC_IDX_W-1:0]] <= frame.id;
          cnt[wpar] <= cnt[wpar] + 1'b1;
        end
        if (frame.chan) begin
          dev_b[wpar][hit ? hit_idx : cnt[wpar][`CSC_IDX_W-1:0]] <= frame.dev;
          vb[wpar][hit ? hit_idx : cnt[wpar][`CSC_IDX_W-1:0]]    <= 1'b1;
        end else begin
          dev_a[wpar][hit ? hit_idx : cnt[wpar][`CSC_IDX_W-1:0]] <= frame.dev;
          va[wpar][hit ? hit_idx : cnt[wpar][`CSC_IDX_W-1:0]]    <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync_nodes_even <= '0;
      sync_nodes_odd  <= '0;
    end else begin
      sync_nodes_even <= cnt[`CSC_PAR_EVEN];
      sync_nodes_odd  <= cnt[`CSC_PAR_ODD];
    end
  end

  // Frame beyond the sixteenth node is dropped; a drop in the clearing cycle still shows
  always_ff @(posedge clk) begin
    if (!rstn)
      table_overflow <= 1'b0;
    else if (frame.valid && !hit && full)
      table_overflow <= 1'b1;
    else if (nit_start)
      table_overflow <= 1'b0;
  end

  // Counters saturate rather than wrap so a noisy channel cannot look quiet
  always_ff @(posedge clk) begin
    if (!rstn) begin
      su_a <= '0;
      su_b <= '0;
    end else begin
      if (frame.valid && frame.startup && !frame.chan)
        su_a <= su_clear ? `CSC_SU_W'(1) : (su_a == `CSC_SU_MAX ? su_a : su_a + 1'b1);
      else if (su_clear)
        su_a <= '0;
      if (frame.valid && frame.startup && frame.chan)
        su_b <= su_clear ? `CSC_SU_W'(1) : (su_b == `CSC_SU_MAX ? su_b : su_b + 1'b1);
      else if (su_clear)
        su_b <= '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn)
      startup_count <= '0;
    else
      startup_count <= (su_a > su_b) ? su_a : su_b;
  end

  // Offset from odd-cycle deviations, rate from odd minus even of the same node and slot
  always_comb begin
    next_omin = omin;
    next_omax = omax;
    next_rmin = rmin;
    next_rmax = rmax;
    next_oany = oany;
    next_rany = rany;
    if (va[`CSC_PAR_ODD][idx]) begin
      next_omin = (!next_oany || wide(dev_a[1][idx]) < next_omin) ? wide(dev_a[1][idx]) : next_omin;
      next_omax = (!next_oany || wide(dev_a[1][idx]) > next_omax) ? wide(dev_a[1][idx]) : next_omax;
      next_oany = 1'b1;
    end
    if (vb[`CSC_PAR_ODD][idx]) begin
      next_omin = (!next_oany || wide(dev_b[1][idx]) < next_omin) ? wide(dev_b[1][idx]) : next_omin;
      next_omax = (!next_oany || wide(dev_b[1][idx]) > next_omax) ? wide(dev_b[1][idx]) : next_omax;
      next_oany = 1'b1;
    end
    if (tid[0][idx] == tid[1][idx] && va[0][idx] && va[1][idx]) begin
      next_rmin = (!next_rany || wide(dev_a[1][idx]) - wide(dev_a[0][idx]) < next_rmin) ?
                  wide(dev_a[1][idx]) - wide(dev_a[0][idx]) : next_rmin;
      next_rmax = (!next_rany || wide(dev_a[1][idx]) - wide(dev_a[0][idx]) > next_rmax) ?
                  wide(dev_a[1][idx]) - wide(dev_a[0][idx]) : next_rmax;
      next_rany = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= CSC_IDLE;
      idx   <= '0;
      go    <= 1'b0;
      {oany, rany} <= 2'b00;
      {omin, omax, rmin, rmax} <= '0;
    end else begin
      go <= 1'b0;
      case (state)
        CSC_IDLE: begin
          idx          <= '0;
          {oany, rany} <= 2'b00;
          if (calc_start)
            state <= CSC_SCAN;
        end
        CSC_SCAN: begin
          {omin, omax, rmin, rmax} <= {next_omin, next_omax, next_rmin, next_rmax};
          {oany, rany} <= {next_oany, next_rany};
          idx          <= idx + 1'b1;
          if (idx == `CSC_IDX_W'(N - 1))
            state <= CSC_DONE;
        end
        CSC_DONE: begin
          go    <= 1'b1;
          state <= CSC_IDLE;
        end
        default: state <= CSC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn)
      calc_busy <= 1'b0;
    else
      calc_busy <= (state == CSC_IDLE) ? calc_start : (state != CSC_DONE);
  end

  csc_calc u_calc (
    .clk        (clk),
    .rstn       (rstn),
    .go         (go),
    .offset_any (oany),
    .offset_raw (mid(omin, omax)),
    .rate_any   (rany),
    .rate_raw   (mid(rmin, rmax)),
    .cfg        (cfg),
    .result     (result)
  );

  // Internal count runs on for one tick after a reset and restarts on the second; the host view does not wait
  assign next_mt = mt_tick ? mt_internal + 1'b1 : mt_internal;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mt_internal <= '0;
      runon       <= '0;
    end else if (mt_reset) begin
      mt_internal <= next_mt;
      runon       <= `CSC_MT_RUNON;
    end else if (runon != 2'h0 && mt_tick) begin
      runon       <= runon - 1'b1;
      mt_internal <= (runon == 2'h1) ? '0 : next_mt;
    end else begin
      mt_internal <= next_mt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn)
      macrotick_value <= '0;
    else if (mt_reset || runon != 2'h0)
      macrotick_value <= '0;
    else
      macrotick_value <= next_mt;
  end

  clear_even_a: assert property (@(posedge clk) disable iff (!rstn)
    nit_start && cycle_odd ##1 1'b1 |=> sync_nodes_even == 0)
    else $error("even table not cleared in odd idle time");
  keep_odd_a: assert property (@(posedge clk) disable iff (!rstn)
    nit_start && cycle_odd && !frame.valid |=> cnt[1] == $past(cnt[1]))
    else $error("odd table disturbed by even clear");
  su_chan_a: assert property (@(posedge clk) disable iff (!rstn)
    frame.valid && frame.startup && !frame.chan && !su_clear && su_a < 5'h1e
    |=> su_a == $past(su_a) + 1'b1 && su_b == $past(su_b))
    else $error("startup count went to wrong channel");
  su_max_a: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> startup_count >= $past(su_a) && startup_count >= $past(su_b)
    && (startup_count == $past(su_a) || startup_count == $past(su_b)))
    else $error("startup count is not the larger channel");
  node_max_a: assert property (@(posedge clk) disable iff (!rstn)
    frame.valid && !hit && full |=> table_overflow && cnt[$past(wpar)] == 5'h10)
    else $error("seventeenth node not refused");
  node_fill_a: assert property (@(posedge clk) disable iff (!rstn)
    frame.valid && !hit && !full && !(nit_start && cpar == wpar)
    |=> cnt[$past(wpar)] == $past(cnt[wpar]) + 1'b1)
    else $error("new sync node not taken");
  mt_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    mt_reset ##1 !mt_reset |-> macrotick_value == 0 ##1 macrotick_value == 0)
    else $error("host macrotick not zero after reset");
  mt_runon_a: assert property (@(posedge clk) disable iff (!rstn)
    mt_reset ##1 mt_tick && !mt_reset |=> mt_internal == $past(mt_internal) + 1'b1)
    else $error("internal macrotick stopped at reset");
endmodule
`default_nettype wire

// >>> test/csc_node_model.sv
// Behavioural model of the remote sync nodes whose frames the block measures
`timescale 1ns/1ps
`default_nettype none
`include "csc_map.svh"
module csc_node_model (
  // Clock
  input  wire logic             clk,
  // Frames towards the block
  output var  csc_pkg::csc_frame_t frame
);
  import csc_pkg::*;
  csc_frame_t pend[$];
  csc_frame_t last;

  initial begin
    frame = '0;
    last  = '0;
  end

  // One frame per cycle; idle fields toggle so a stale frame never looks settled
  always @(posedge clk) begin
    #1;
    if (pend.size() != 0) begin
      last = pend.pop_front();
    end else begin
      last = ~last;
      last.valid = 1'b0;
    end
    frame = last;
  end

  task automatic send(input logic chan, input logic su, input logic [`CSC_ID_W-1:0] id,
                      input logic [`CSC_DEV_W-1:0] dev);
    pend.push_back({1'b1, chan, su, id, dev});
    while (pend.size() != 0) @(posedge clk);
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the clock sync correction block
`timescale 1ns/1ps
`default_nettype none
`include "csc_map.svh"
module tb;
  import csc_pkg::*;
  logic                  clk, rstn, nit_start, cycle_odd, calc_start, mt_tick, mt_reset;
  csc_frame_t            frame;
  csc_cfg_t              cfg;
  csc_result_t           result;
  logic [`CSC_SU_W-1:0]  startup_count;
  logic [`CSC_CNT_W-1:0] sync_nodes_even, sync_nodes_odd;
  logic                  table_overflow, calc_busy;
  logic [`CSC_MT_W-1:0]  macrotick_value, mt_internal;
  int                    num_errors = 0;
  int                    cmp_count = 0;
  logic [35:0]           notes[$];
  logic [35:0]           n;
  int                    e[2], o[2], ob, off_raw, rate_raw;

  csc_top i_csc_top (.clk(clk), .rstn(rstn), .nit_start(nit_start), .cycle_odd(cycle_odd),
    .calc_start(calc_start), .frame(frame), .cfg(cfg), .mt_tick(mt_tick),
    .mt_reset(mt_reset), .result(result), .startup_count(startup_count),
    .sync_nodes_even(sync_nodes_even), .sync_nodes_odd(sync_nodes_odd),
    .table_overflow(table_overflow), .calc_busy(calc_busy),
    .macrotick_value(macrotick_value), .mt_internal(mt_internal));

  csc_node_model i_csc_node_model (.clk(clk), .frame(frame));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic wrap_up();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic node(input logic ch, input logic su, input int id, input int dev);
    i_csc_node_model.send(ch, su, 11'(id), 16'(dev));
    #1;
  endtask

  task automatic idle_start(input logic odd);
    cycle_odd = odd;
    nit_start = 1'b1;
    step(1);
    nit_start = 1'b0;
  endtask

  // Expected fail flag and term: limit judged on the raw value, external term added after
  function automatic logic [17:0] exp_term(input int raw, input int lim, input int ext);
    logic fail;
    int   t;
    fail = (raw > lim) || (raw < -lim);
    t = fail ? ((raw > 0) ? lim : -lim) : raw;
    return {fail, 17'(t + ext)};
  endfunction

  task automatic calc(input int lo, input int lr, input int xo, input int xr);
    logic [17:0] a, b;
    int          k;
    cfg = '{offset_limit: 17'(lo), rate_limit: 17'(lr), ext_offset: 17'(xo), ext_rate: 17'(xr)};
    a = exp_term(off_raw, lo, xo);
    b = exp_term(rate_raw, lr, xr);
    notes.push_back({a[17], b[17], a[16:0], b[16:0]});
    calc_start = 1'b1;
    step(1);
    chk("calc_busy", 40'h00_0000_0001, 40'(calc_busy));
    // Start held into the scan must be ignored, else a spare done would follow
    step(1);
    calc_start = 1'b0;
    k = 0;
    while (result.done !== 1'b1 && k < 40) begin
      step(1);
      k++;
    end
    if (k >= 40) begin
      num_errors++;
      $display("MISMATCH done expected 1 seen %b", result.done);
    end
    step(2);
    chk("calc_busy", 40'h00_0000_0000, 40'(calc_busy));
  endtask

  // Results are matched against the oldest note whenever the scan reports done
  always @(posedge clk) begin
    if (result.done === 1'b1) begin
      if (notes.size() == 0) begin
        num_errors++;
        $display("MISMATCH done expected 0 seen 1");
      end else begin
        n = notes.pop_front();
        chk("offset_fail", 40'(n[35]), 40'(result.offset_fail));
        chk("rate_fail", 40'(n[34]), 40'(result.rate_fail));
        chk("offset_term", 40'(n[33:17]), 40'(result.offset_correction_term));
        chk("rate_term", 40'(n[16:0]), 40'(result.rate_correction_term));
      end
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h0000_b306));
    {rstn, nit_start, cycle_odd, calc_start, mt_tick, mt_reset} = '0;
    cfg = '0;
    step(3);
    rstn = 1'b1;
    step(1);
    chk("result", 40'h00_0000_0000, 40'(result));
    chk("macrotick_value", 40'h00_0000_0000, 40'(macrotick_value));
    // Even cycle: two sync nodes, startup frames 2 on A and 1 on B
    for (int i = 0; i < 2; i++) begin
      e[i] = $urandom % 50;
      node(1'b0, 1'b1, i + 1, e[i]);
    end
    node(1'b1, 1'b1, 1, 0);
    step(3);
    chk("sync_nodes_even", 40'h00_0000_0002, 40'(sync_nodes_even));
    chk("startup_count", 40'h00_0000_0002, 40'(startup_count));
    idle_start(1'b0);
    cycle_odd = 1'b1;
    for (int i = 0; i < 2; i++) begin
      o[i] = e[i] + 100 + $urandom % 100;
      node(1'b0, 1'b0, i + 1, o[i]);
    end
    ob = 100 + $urandom % 100;
    node(1'b1, 1'b0, 1, ob);
    step(3);
    chk("sync_nodes_odd", 40'h00_0000_0002, 40'(sync_nodes_odd));
    chk("sync_nodes_even", 40'h00_0000_0002, 40'(sync_nodes_even));
    off_raw = (((ob < o[0]) ? ((ob < o[1]) ? ob : o[1]) : ((o[0] < o[1]) ? o[0] : o[1]))
             + ((ob > o[0]) ? ((ob > o[1]) ? ob : o[1]) : ((o[0] > o[1]) ? o[0] : o[1]))) / 2;
    rate_raw = ((o[0] - e[0]) + (o[1] - e[1])) / 2;
    // Raw within limit but raw plus external beyond it: must not fail
    calc(300, 300, 250, 250);
    calc(50, 50, -7, -7);
    idle_start(1'b1);
    step(1);
    chk("sync_nodes_even", 40'h00_0000_0000, 40'(sync_nodes_even));
    chk("startup_count", 40'h00_0000_0000, 40'(startup_count));
    chk("sync_nodes_odd", 40'h00_0000_0002, 40'(sync_nodes_odd));
    idle_start(1'b0);
    step(1);
    chk("sync_nodes_odd", 40'h00_0000_0000, 40'(sync_nodes_odd));
    cycle_odd = 1'b1;
    for (int i = 0; i < 17; i++) begin
      node(1'b0, 1'b0, 100 + i, $urandom);
    end
    node(1'b1, 1'b0, 100, 5);
    step(3);
    chk("sync_nodes_odd", 40'h00_0000_0010, 40'(sync_nodes_odd));
    chk("table_overflow", 40'h00_0000_0001, 40'(table_overflow));
    for (int i = 0; i < 5; i++) begin
      mt_tick = 1'b1;
      step(1);
      mt_tick = 1'b0;
      step(1);
    end
    step(1);
    chk("mt_internal", 40'h00_0000_0005, 40'(mt_internal));
    chk("macrotick_value", 40'h00_0000_0005, 40'(macrotick_value));
    mt_reset = 1'b1;
    step(1);
    mt_reset = 1'b0;
    chk("macrotick_value", 40'h00_0000_0000, 40'(macrotick_value));
    mt_tick = 1'b1;
    step(1);
    mt_tick = 1'b0;
    chk("mt_internal", 40'h00_0000_0006, 40'(mt_internal));
    chk("macrotick_value", 40'h00_0000_0000, 40'(macrotick_value));
    step(2);
    // Second tick ends the run-on: internal count restarts, host view follows after
    mt_tick = 1'b1;
    step(1);
    mt_tick = 1'b0;
    chk("mt_internal", 40'h00_0000_0000, 40'(mt_internal));
    chk("macrotick_value", 40'h00_0000_0000, 40'(macrotick_value));
    step(1);
    mt_tick = 1'b1;
    step(1);
    mt_tick = 1'b0;
    chk("mt_internal", 40'h00_0000_0001, 40'(mt_internal));
    chk("macrotick_value", 40'h00_0000_0001, 40'(macrotick_value));
    step(2);
    wrap_up();
  end
endmodule
`default_nettype wire
